// ===== uvs_consts.vh
/*
 Constants for the undervoltage torque limit supervisor: register offsets, field positions,
 reset values and timing counts. Assumes a 125 MHz pclk.
*/
`ifndef UVS_CONSTS_VH
`define UVS_CONSTS_VH
`define UVS_CLK_HZ 125000000
`define UVS_MS_CYCLES (`UVS_CLK_HZ / 1000)
`define UVS_OFF_CTRL 12'h000
`define UVS_OFF_TQLIM 12'h004
`define UVS_OFF_RELTIME 12'h008
`define UVS_OFF_HOLDTIME 12'h00c
`define UVS_OFF_ROTMAX 12'h010
`define UVS_OFF_LINMAX 12'h014
`define UVS_OFF_THRESH 12'h018
`define UVS_OFF_STATUS 12'h01c
`define UVS_OFF_IRQ_STAT 12'h020
`define UVS_OFF_IRQ_EN 12'h024
`define UVS_OFF_IRQ_CLR 12'h028
`define UVS_OFF_ENC_MAX 12'h02c
`define UVS_SEL_NONE 2'h0
`define UVS_SEL_HOST 2'h1
`define UVS_SEL_INTERNAL 2'h2
`define UVS_CTRL_SEL_LSB 4
`define UVS_CTRL_LINEAR_BIT 8
`define UVS_TQLIM_RST 7'h32
`define UVS_TQLIM_MAX 7'h64
`define UVS_RELTIME_RST 10'h064
`define UVS_RELTIME_MAX 10'h3e8
`define UVS_HOLDTIME_RST 16'h0014
`define UVS_HOLDTIME_MIN 16'h0014
`define UVS_HOLDTIME_MAX 16'hc350
`define UVS_ROTMAX_RST 16'h2710
`define UVS_LINMAX_RST 7'h32
`define UVS_LINMAX_MIN 7'h01
`define UVS_LINMAX_MAX 7'h64
`define UVS_THRESH_RST 16'h0000
`define UVS_WARN_UV_CODE 12'h971
`define UVS_ALARM_OS_CODE 12'h510
`define UVS_IRQ_UV_SET 0
`define UVS_IRQ_UV_CLR 1
`define UVS_IRQ_OVERSPEED 2
`define UVS_IRQ_HOLD_EXPIRED 3
`define UVS_IRQ_W 4
`endif

// ===== uvs_ms_timer.v
/*
 Millisecond down counter: loads a count of milliseconds and reports when it runs out.
 Assumes a one-cycle millisecond tick from the parent.
*/
`timescale 1ns/10ps
module uvs_ms_timer #(
  parameter W = 16
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Control.
  input wire ms_tick,
  input wire load,
  input wire [W-1:0] load_ms,
  input wire run,
  // Status.
  output wire expired,
  output reg busy_reg
);
  reg [W-1:0] count_reg;
  assign expired = busy_reg && run && ms_tick && (count_reg <= {{(W-1){1'b0}}, 1'b1});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {W{1'b0}};
      busy_reg <= 1'b0;
    end else if (load) begin
      count_reg <= load_ms;
      busy_reg <= (load_ms != {W{1'b0}});
    end else if (!run) begin
      busy_reg <= 1'b0;
    end else if (expired) begin
      count_reg <= {W{1'b0}};
      busy_reg <= 1'b0;
    end else if (busy_reg && ms_tick) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ===== uvs_supervisor.v
/*
 Undervoltage torque limit supervisor with APB register file and interrupt.
 Assumes synchronous inputs on pclk, an APB master, and a host that applies its own torque
 limit while the undervoltage warning is reported in host mode.
*/
// Design decisions made here: the APB interface to the registers and the placing of the registers.
// Summary of operation
// - Bus voltage at or below threshold with detection enabled raises warning 971; internal mode limits current.
// - Selection defaults to no detection; then no undervoltage warning is raised.
// - In internal mode the drive applies its own drop torque limit during the warning.
// - In internal mode the limit stays for the release time after the warning clears.
// - Drop torque limit 0 to 100 percent, default 50, effective immediately.
// - Release time 0 to 1000 ms, default 100, effective immediately.
// - Interruption hold time 20 to 50000 ms, default 20, effective immediately.
// - Servo-off removes motor power at once, whatever hold time remains.
// - Speed above the configured maximum raises overspeed alarm 510.
// - Rotary maximum speed 0 to 65535 rpm, default 10000, applied after restart.
// - Linear maximum speed 1 to 100 units of 100 mm/s, default 50, after restart.
// - Lower linear maximum speed raises the encoder output resolution upper bound.
// - Interruption within hold time keeps motor power; longer stops it until recovery.
// - Interruption beyond the hold time drops servo ready.
`timescale 1ns/10ps
`include "uvs_consts.vh"
module uvs_supervisor #(
  parameter integer MS_CYCLES = `UVS_MS_CYCLES,
  parameter integer ENC_RES_BASE = 6500
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Drive inputs.
  input wire [15:0] bus_voltage,
  input wire main_power_ok,
  input wire [15:0] motor_speed,
  input wire servo_on_cmd,
  input wire restart,
  // Drive outputs.
  output reg undervoltage_warning,
  output reg [11:0] warning_code,
  output reg torque_limit_active,
  output reg [6:0] torque_limit_pct,
  output reg overspeed_alarm,
  output reg [11:0] alarm_code,
  output reg motor_power,
  output reg servo_ready,
  output wire irq
);
  localparam TQ_IDLE = 3'b001;
  localparam TQ_LIMIT = 3'b010;
  localparam TQ_RELEASE = 3'b100;
  localparam PWR_ON = 3'b001;
  localparam PWR_HOLD = 3'b010;
  localparam PWR_LOST = 3'b100;
  reg [1:0] sel_cfg_reg;
  reg [1:0] sel_act_reg;
  reg linear_cfg_reg;
  reg linear_act_reg;
  reg [6:0] tqlim_reg;
  reg [9:0] reltime_reg;
  reg [15:0] holdtime_reg;
  reg [15:0] rotmax_cfg_reg;
  reg [15:0] rotmax_act_reg;
  reg [6:0] linmax_cfg_reg;
  reg [6:0] linmax_act_reg;
  reg [15:0] thresh_reg;
  reg [`UVS_IRQ_W-1:0] irq_stat_reg;
  reg [`UVS_IRQ_W-1:0] irq_en_reg;
  reg [31:0] div_reg;
  reg uv_reg;
  reg [2:0] tq_state_reg;
  reg [2:0] tq_state_next;
  reg pwr_lost_reg;
  reg [2:0] pwr_state_reg;
  reg [2:0] pwr_state_next;
  reg os_reg;
  reg [`UVS_IRQ_W-1:0] irq_set;
  reg [`UVS_IRQ_W-1:0] irq_clr;
  reg [31:0] rd_next;
  reg [31:0] enc_max_next;
  wire ms_tick;
  wire wr;
  wire rd;
  wire uv_detect;
  wire uv_rise;
  wire uv_fall;
  wire [16:0] speed_limit;
  wire os_now;
  wire rel_expired;
  wire rel_busy;
  wire hold_expired;
  wire hold_busy;
  wire [15:0] rel_load_ms;
  wire tq_internal;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign irq = |(irq_stat_reg & irq_en_reg);
  assign ms_tick = (div_reg == (MS_CYCLES - 1));
  assign uv_detect = (sel_act_reg != `UVS_SEL_NONE) && (bus_voltage <= thresh_reg);
  assign uv_rise = uv_detect && !uv_reg;
  assign uv_fall = !uv_detect && uv_reg;
  assign speed_limit = linear_act_reg ? ({10'h000, linmax_act_reg} * 17'd1) : {1'b0, rotmax_act_reg};
  assign os_now = ({1'b0, motor_speed} > speed_limit);
  assign rel_load_ms = {6'h00, reltime_reg};
  assign tq_internal = (sel_act_reg == `UVS_SEL_INTERNAL);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 32'h00000000;
    end else if (ms_tick) begin
      div_reg <= 32'h00000000;
    end else begin
      div_reg <= div_reg + 32'h00000001;
    end
  end
  // Release timer restarts at each warning clear and is dropped if the warning returns.
  uvs_ms_timer #(.W(16)) u_rel (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .load(uv_fall && (sel_act_reg == `UVS_SEL_INTERNAL)),
    .load_ms(rel_load_ms),
    .run(!uv_reg && (sel_act_reg == `UVS_SEL_INTERNAL)),
    .expired(rel_expired),
    .busy_reg(rel_busy)
  );
  // Hold timer starts when main power drops and runs while it stays down.
  uvs_ms_timer #(.W(16)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .load(!main_power_ok && !pwr_lost_reg),
    .load_ms(holdtime_reg),
    .run(!main_power_ok),
    .expired(hold_expired),
    .busy_reg(hold_busy)
  );
  // Register writes, restart latching and interrupt status.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cfg_reg <= `UVS_SEL_NONE;
      sel_act_reg <= `UVS_SEL_NONE;
      linear_cfg_reg <= 1'b0;
      linear_act_reg <= 1'b0;
      tqlim_reg <= `UVS_TQLIM_RST;
      reltime_reg <= `UVS_RELTIME_RST;
      holdtime_reg <= `UVS_HOLDTIME_RST;
      rotmax_cfg_reg <= `UVS_ROTMAX_RST;
      rotmax_act_reg <= `UVS_ROTMAX_RST;
      linmax_cfg_reg <= `UVS_LINMAX_RST;
      linmax_act_reg <= `UVS_LINMAX_RST;
      thresh_reg <= `UVS_THRESH_RST;
      irq_en_reg <= {`UVS_IRQ_W{1'b0}};
      irq_stat_reg <= {`UVS_IRQ_W{1'b0}};
    end else begin
      if (restart) begin
        sel_act_reg <= sel_cfg_reg;
        linear_act_reg <= linear_cfg_reg;
        rotmax_act_reg <= rotmax_cfg_reg;
        linmax_act_reg <= linmax_cfg_reg;
      end
      if (wr) begin
        case (paddr)
          `UVS_OFF_CTRL: begin
            sel_cfg_reg <= (pwdata[`UVS_CTRL_SEL_LSB+1:`UVS_CTRL_SEL_LSB] == 2'h3) ?
              sel_cfg_reg : pwdata[`UVS_CTRL_SEL_LSB+1:`UVS_CTRL_SEL_LSB];
            linear_cfg_reg <= pwdata[`UVS_CTRL_LINEAR_BIT];
          end
          `UVS_OFF_TQLIM: begin
            if (pwdata[31:0] <= {25'h0000000, `UVS_TQLIM_MAX}) begin
              tqlim_reg <= pwdata[6:0];
            end
          end
          `UVS_OFF_RELTIME: begin
            if (pwdata[31:0] <= {22'h000000, `UVS_RELTIME_MAX}) begin
              reltime_reg <= pwdata[9:0];
            end
          end
          `UVS_OFF_HOLDTIME: begin
            if (pwdata[31:16] == 16'h0000 && pwdata[15:0] >= `UVS_HOLDTIME_MIN &&
                pwdata[15:0] <= `UVS_HOLDTIME_MAX) begin
              holdtime_reg <= pwdata[15:0];
            end
          end
          `UVS_OFF_ROTMAX: begin
            rotmax_cfg_reg <= pwdata[15:0];
          end
          `UVS_OFF_LINMAX: begin
            if (pwdata[31:7] == 25'h0000000 && pwdata[6:0] >= `UVS_LINMAX_MIN &&
                pwdata[6:0] <= `UVS_LINMAX_MAX) begin
              linmax_cfg_reg <= pwdata[6:0];
            end
          end
          `UVS_OFF_THRESH: begin
            thresh_reg <= pwdata[15:0];
          end
          `UVS_OFF_IRQ_EN: begin
            irq_en_reg <= pwdata[`UVS_IRQ_W-1:0];
          end
          default: begin
          end
        endcase
      end
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end
  always @* begin
    irq_set = {`UVS_IRQ_W{1'b0}};
    irq_set[`UVS_IRQ_UV_SET] = uv_rise;
    irq_set[`UVS_IRQ_UV_CLR] = uv_fall;
    irq_set[`UVS_IRQ_OVERSPEED] = os_now && !os_reg;
    irq_set[`UVS_IRQ_HOLD_EXPIRED] = hold_expired;
    irq_clr = (wr && paddr == `UVS_OFF_IRQ_CLR) ? pwdata[`UVS_IRQ_W-1:0] : {`UVS_IRQ_W{1'b0}};
  end
  // The encoder resolution ceiling scales inversely with the linear speed ceiling.
  always @* begin
    enc_max_next = ENC_RES_BASE * 100 / {25'h0000000, linmax_act_reg};
  end
  always @* begin
    rd_next = 32'h00000000;
    case (paddr)
      `UVS_OFF_CTRL: rd_next = {23'h000000, linear_cfg_reg, 2'h0, sel_cfg_reg, 4'h0};
      `UVS_OFF_TQLIM: rd_next = {25'h0000000, tqlim_reg};
      `UVS_OFF_RELTIME: rd_next = {22'h000000, reltime_reg};
      `UVS_OFF_HOLDTIME: rd_next = {16'h0000, holdtime_reg};
      `UVS_OFF_ROTMAX: rd_next = {16'h0000, rotmax_cfg_reg};
      `UVS_OFF_LINMAX: rd_next = {25'h0000000, linmax_cfg_reg};
      `UVS_OFF_THRESH: rd_next = {16'h0000, thresh_reg};
      `UVS_OFF_STATUS: rd_next = {20'h00000, hold_busy, rel_busy, servo_ready, motor_power,
        overspeed_alarm, torque_limit_active, undervoltage_warning, sel_act_reg, linear_act_reg,
        2'h0};
      `UVS_OFF_IRQ_STAT: rd_next = {28'h0000000, irq_stat_reg};
      `UVS_OFF_IRQ_EN: rd_next = {28'h0000000, irq_en_reg};
      `UVS_OFF_ENC_MAX: rd_next = linear_act_reg ? enc_max_next : 32'h00000000;
      default: rd_next = 32'h00000000;
    endcase
  end
  // Internal-mode torque limit: held through the warning, then for the release time.
  always @* begin
    tq_state_next = tq_state_reg;
    case (tq_state_reg)
      TQ_IDLE: begin
        if (tq_internal && uv_detect) begin
          tq_state_next = TQ_LIMIT;
        end
      end
      TQ_LIMIT: begin
        if (!tq_internal) begin
          tq_state_next = TQ_IDLE;
        end else if (!uv_detect) begin
          if (reltime_reg != 10'h000) begin
            tq_state_next = TQ_RELEASE;
          end else begin
            tq_state_next = TQ_IDLE;
          end
        end
      end
      TQ_RELEASE: begin
        if (!tq_internal) begin
          tq_state_next = TQ_IDLE;
        end else if (uv_detect) begin
          tq_state_next = TQ_LIMIT;
        end else if (rel_expired || !rel_busy) begin
          tq_state_next = TQ_IDLE;
        end
      end
      default: begin
        tq_state_next = TQ_IDLE;
      end
    endcase
  end
  // Main power supervision: ride through a dip for the hold time, then drop power until recovery.
  always @* begin
    pwr_state_next = pwr_state_reg;
    case (pwr_state_reg)
      PWR_ON: begin
        if (!main_power_ok) begin
          pwr_state_next = PWR_HOLD;
        end
      end
      PWR_HOLD: begin
        if (main_power_ok) begin
          pwr_state_next = PWR_ON;
        end else if (hold_expired) begin
          pwr_state_next = PWR_LOST;
        end
      end
      PWR_LOST: begin
        if (main_power_ok) begin
          pwr_state_next = PWR_ON;
        end
      end
      default: begin
        pwr_state_next = PWR_ON;
      end
    endcase
  end
  // Supervisor state and outputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      uv_reg <= 1'b0;
      tq_state_reg <= TQ_IDLE;
      pwr_lost_reg <= 1'b0;
      pwr_state_reg <= PWR_ON;
      os_reg <= 1'b0;
      undervoltage_warning <= 1'b0;
      warning_code <= 12'h000;
      torque_limit_active <= 1'b0;
      torque_limit_pct <= `UVS_TQLIM_MAX;
      overspeed_alarm <= 1'b0;
      alarm_code <= 12'h000;
      motor_power <= 1'b0;
      servo_ready <= 1'b0;
    end else begin
      if (rd) begin
        prdata <= rd_next;
      end
      uv_reg <= uv_detect;
      undervoltage_warning <= uv_detect;
      warning_code <= uv_detect ? `UVS_WARN_UV_CODE : 12'h000;
      tq_state_reg <= tq_state_next;
      // Internal mode limits during the warning and through the release window.
      torque_limit_active <= (tq_state_next != TQ_IDLE);
      torque_limit_pct <= tqlim_reg;
      os_reg <= os_now;
      if (os_now) begin
        overspeed_alarm <= 1'b1;
        alarm_code <= `UVS_ALARM_OS_CODE;
      end else if (restart) begin
        overspeed_alarm <= 1'b0;
        alarm_code <= 12'h000;
      end
      pwr_lost_reg <= !main_power_ok;
      pwr_state_reg <= pwr_state_next;
      // Servo-off wins immediately over any remaining hold time.
      motor_power <= servo_on_cmd && !overspeed_alarm && (pwr_state_next != PWR_LOST);
      servo_ready <= !overspeed_alarm && (pwr_state_next != PWR_LOST);
    end
  end
endmodule

// ===== uvs_supervisor_assertions.sv
/*
 Checker for the supervisor ports, bound to uvs_supervisor.
 Assumes MS_CYCLES of 10 in simulation.
*/
`timescale 1ns/10ps
module uvs_chk (
  // Clock, reset and bus.
  input pclk,
  input presetn,
  input psel,
  input penable,
  input pready,
  input pslverr,
  // Drive signals.
  input main_power_ok,
  input servo_on_cmd,
  input restart,
  input undervoltage_warning,
  input [11:0] warning_code,
  input [6:0] torque_limit_pct,
  input overspeed_alarm,
  input [11:0] alarm_code,
  input motor_power
);
  reg [8:0] lost_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) lost_cnt <= 9'h000;
    else if (main_power_ok) lost_cnt <= 9'h000;
    else if (lost_cnt != 9'h1ff) lost_cnt <= lost_cnt + 9'h001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_acc;
    psel && !penable ##1 psel && penable;
  endsequence
  apb_done_a: assert property (apb_acc |-> pready && !pslverr) else $error("apb access not zero wait");
  warn_code_a: assert property (warning_code == (undervoltage_warning ? 12'h971 : 12'h000))
    else $error("warning code mismatch");
  alarm_code_a: assert property (alarm_code == (overspeed_alarm ? 12'h510 : 12'h000))
    else $error("alarm code mismatch");
  os_hold_a: assert property (overspeed_alarm && !restart |=> overspeed_alarm)
    else $error("overspeed alarm dropped");
  servo_off_a: assert property (!servo_on_cmd |=> !motor_power) else $error("power kept at servo off");
  tq_range_a: assert property (torque_limit_pct <= 7'h64) else $error("torque limit above range");
  hold_min_a: assert property ($fell(motor_power) && $past(servo_on_cmd) && !overspeed_alarm
    && !$past(main_power_ok) |-> lost_cnt >= 9'd190) else $error("power dropped inside hold");
  power_on_a: assert property ($rose(motor_power) |-> $past(servo_on_cmd))
    else $error("power rose while off");
endmodule
bind uvs_supervisor uvs_chk u_chk (.*);

// ===== uvs_host_model.sv
/*
 Host controller model: holds its own torque limit in host mode.
 Assumes the bench tells it which mode is active.
*/
`timescale 1ns/10ps
module uvs_host_model (
  // Clock and reset.
  input pclk,
  input presetn,
  // Drive status and mode.
  input host_mode,
  input undervoltage_warning,
  // Host torque limit.
  output reg host_limit
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) host_limit <= 1'b0;
    else host_limit <= host_mode & undervoltage_warning;
  end
endmodule

// ===== tb_top.sv
/*
 Self-checking bench for uvs_supervisor.
 Assumes APB zero wait answers and a shortened millisecond.
*/
`timescale 1ns/10ps
module tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, main_power_ok = 1, servo_on_cmd = 1;
  reg restart = 0, host_mode = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, r, tq_v;
  reg [15:0] bus_voltage = 16'hffff, motor_speed = 0;
  wire pready, pslverr, warn, tq_act, os_alarm, mpow, srdy, irq, host_limit;
  wire [31:0] prdata;
  wire [11:0] wcode, acode;
  wire [6:0] tq_pct;
  integer fails = 0, n_compared = 0, seed = 97338, i;
  localparam integer ENC_BASE = 6500;
  always #4 pclk = ~pclk;
  uvs_supervisor #(.MS_CYCLES(10), .ENC_RES_BASE(ENC_BASE)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .bus_voltage(bus_voltage), .main_power_ok(main_power_ok), .motor_speed(motor_speed),
    .servo_on_cmd(servo_on_cmd), .restart(restart), .undervoltage_warning(warn), .warning_code(wcode),
    .torque_limit_active(tq_act), .torque_limit_pct(tq_pct), .overspeed_alarm(os_alarm),
    .alarm_code(acode), .motor_power(mpow), .servo_ready(srdy), .irq(irq));
  uvs_host_model u_host (.pclk(pclk), .presetn(presetn), .host_mode(host_mode),
    .undervoltage_warning(warn), .host_limit(host_limit));
  task wrap_up;
    begin
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      n_compared++;
      if (g !== e) begin
        fails++;
        $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin @(posedge pclk); k++; r = prdata; end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin fails++; wrap_up; end
      psel <= 0; penable <= 0;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin xfer(0, a, 0); chk("reg", e, r); end
  endtask
  function [31:0] enc_ceiling(input [6:0] m);
    begin
      enc_ceiling = ENC_BASE * 100 / m;
    end
  endfunction
  task cyc(input integer n);
    begin repeat (n) @(posedge pclk); end
  endtask
  task pulse_restart;
    begin @(posedge pclk); restart <= 1; @(posedge pclk); restart <= 0; cyc(3); end
  endtask
  initial begin
    cyc(16);
    presetn <= 1;
    rdc(12'h004, 50); rdc(12'h008, 100); rdc(12'h00c, 20);
    rdc(12'h010, 10000); rdc(12'h014, 50); rdc(12'h000, 0); rdc(12'h030, 0);
    rdc(12'h01c, 32'h300); rdc(12'h02c, 0);
    xfer(1, 12'h004, 101); rdc(12'h004, 50); xfer(1, 12'h008, 1001); rdc(12'h008, 100);
    xfer(1, 12'h00c, 19); rdc(12'h00c, 20); xfer(1, 12'h014, 0); rdc(12'h014, 50);
    for (i = 0; i < 4; i++) begin
      tq_v = (i == 0) ? 100 : $unsigned($random(seed)) % 101;
      xfer(1, 12'h004, tq_v); rdc(12'h004, tq_v); chk("tq_pct", tq_v, tq_pct);
    end
    xfer(1, 12'h018, 16'h1000); bus_voltage <= 16'h1000; cyc(4);
    chk("warn_none", 0, warn);
    xfer(1, 12'h000, 32'h20); xfer(1, 12'h008, 5); cyc(4);
    chk("warn_sel_late", 0, warn);
    pulse_restart;
    chk("warn", 1, warn); chk("wcode", 12'h971, wcode); chk("tq_act", 1, tq_act);
    chk("irq_masked", 0, irq);
    xfer(1, 12'h024, 1); cyc(1); chk("irq_on", 1, irq);
    xfer(1, 12'h028, 1); cyc(1); chk("irq_clr", 0, irq);
    bus_voltage <= 16'h1001 + (16'h00ff & $random(seed)); cyc(3);
    chk("warn_clr", 0, warn); cyc(30); chk("tq_hold", 1, tq_act);
    cyc(60); chk("tq_drop", 0, tq_act);
    xfer(1, 12'h000, 32'h10); host_mode <= 1; pulse_restart;
    bus_voltage <= 16'h0800; cyc(3);
    chk("host_warn", 1, warn); chk("host_tq", 0, tq_act); chk("host_lim", 1, host_limit);
    bus_voltage <= 16'h2000; cyc(3); chk("host_rel", 0, host_limit);
    motor_speed <= 16'h2710; cyc(3); chk("os_edge", 0, os_alarm);
    motor_speed <= 16'h2711; cyc(3); chk("os", 1, os_alarm); chk("acode", 12'h510, acode);
    rdc(12'h020, 32'h7);
    motor_speed <= 0; pulse_restart; chk("os_rst", 0, os_alarm);
    xfer(1, 12'h010, 100); motor_speed <= 200; cyc(3); chk("os_late", 0, os_alarm);
    pulse_restart; chk("os_new", 1, os_alarm); motor_speed <= 0; pulse_restart;
    cyc(3); chk("pow_on", 1, mpow);
    servo_on_cmd <= 0; cyc(2); chk("servo_off", 0, mpow); servo_on_cmd <= 1; cyc(5);
    main_power_ok <= 0; cyc(150); chk("hold_pow", 1, mpow); chk("hold_rdy", 1, srdy);
    main_power_ok <= 1; cyc(5); main_power_ok <= 0; cyc(260);
    chk("lost_pow", 0, mpow); chk("lost_rdy", 0, srdy);
    rdc(12'h020, 32'hf);
    main_power_ok <= 1; cyc(5); chk("back_pow", 1, mpow);
    xfer(1, 12'h014, 25); xfer(1, 12'h000, 32'h110); pulse_restart;
    rdc(12'h02c, enc_ceiling(25));
    xfer(1, 12'h00c, 1000); rdc(12'h00c, 1000);
    wrap_up;
  end
endmodule
